// ===== inc/mie_pkg.sv
package mie_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_RAW = 8'h00;
  localparam logic [7:0] OFF_ENSTAT = 8'h04;
  localparam logic [7:0] OFF_ENSET = 8'h08;
  localparam logic [7:0] OFF_ENCLR = 8'h0C;
  localparam int BIT_ERR = 0;
  localparam int BIT_WR = 3;
  localparam int BIT_DB = 4;
  localparam int BIT_SB = 5;
  localparam logic [31:0] SRC_MASK = 32'h0000_0039;
  localparam logic [31:0] RESET_VAL = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    WS_IDLE = 3'b001,
    WS_RESP = 3'b010,
    WS_HOLD = 3'b100
  } mie_wstate_t;
endpackage

// ===== src/mie_src_bit.sv
`timescale 1ns/100ps
// one source: enable flag, raw status flag
module mie_src_bit (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hwEvent,
  input wire logic enSet,
  input wire logic enClr,
  input wire logic rawSet,
  input wire logic statClr,
  output logic enable,
  output logic raw
);
  logic enable_next;
  logic raw_next;
  // set has priority over clear on the same source
  assign enable_next = enSet ? 1'b1 : (enClr ? 1'b0 : enable);
  // hardware or software set wins over clear
  assign raw_next = (hwEvent | rawSet) ? 1'b1 : ((statClr & enable) ? 1'b0 : raw);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      enable <= 1'b0;
      raw <= 1'b0;
    end else begin
      enable <= enable_next;
      raw <= raw_next;
    end
  end
endmodule

// ===== src/mie_irq_ctrl.sv
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
// Notes on behaviour
// - writing one to set bit 5 enables single-bit ECC source, reads one.
// - writing one to set bit 4 enables double-bit ECC source, reads one.
// - writing one to set bit 3 enables write ECC source, reads one.
// - writing one to set bit 0 enables command/address source, reads one.
// - one enable flag per source, seen alike through set and clear registers.
// - writing zero to any enable bit leaves that enable unchanged.
// - writing one to clear bit 5 disables single-bit ECC source.
// - writing one to clear bit 4 disables double-bit ECC source.
// - writing one to clear bit 3 disables write ECC source.
// - writing one to clear bit 0 disables command/address source in both views.
// - bits 31-6 and 2-1 read zero and ignore writes.
// - after reset all enable bits are zero.
// - raw status set by hardware event or software write of one.
// - enabled status is raw gated by enable; writing one clears raw and enabled status only for enabled sources.
module mie_irq_ctrl (
  input wire logic clk,
  input wire logic rstn,
  input wire logic singleBitEccFault,
  input wire logic doubleBitEccFault,
  input wire logic writeEccFault,
  input wire logic cmdAddrFault,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irqOut
);
  // write channel capture
  logic awHave_reg;
  logic wHave_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic awTake;
  logic wTake;
  logic doWrite;
  logic [31:0] wBits;
  logic hitRaw;
  logic hitStat;
  logic hitSet;
  logic hitClr;
  logic wHit;
  logic [31:0] evtVec;
  logic [31:0] enSetVec;
  logic [31:0] enClrVec;
  logic [31:0] rawSetVec;
  logic [31:0] statClrVec;
  logic [31:0] enableVec;
  logic [31:0] rawVec;
  logic [31:0] enStatVec;
  logic [31:0] rdMux;
  logic rdHit;
  logic arTake;
  logic irq_next;

  assign awTake = s_axi_awvalid & s_axi_awready;
  assign wTake = s_axi_wvalid & s_axi_wready;
  assign doWrite = awHave_reg & wHave_reg & ~s_axi_bvalid;
  // only byte lane 0 carries the source bits
  assign wBits = wStrb_reg[0] ? (wData_reg & mie_pkg::SRC_MASK) : mie_pkg::RESET_VAL;
  assign hitRaw = awAddr_reg[7:2] == mie_pkg::OFF_RAW[7:2];
  assign hitStat = awAddr_reg[7:2] == mie_pkg::OFF_ENSTAT[7:2];
  assign hitSet = awAddr_reg[7:2] == mie_pkg::OFF_ENSET[7:2];
  assign hitClr = awAddr_reg[7:2] == mie_pkg::OFF_ENCLR[7:2];
  assign wHit = hitRaw | hitStat | hitSet | hitClr;
  // zero bits produce no strobe, so enables hold
  assign enSetVec = (doWrite & hitSet) ? wBits : mie_pkg::RESET_VAL;
  assign enClrVec = (doWrite & hitClr) ? wBits : mie_pkg::RESET_VAL;
  assign rawSetVec = (doWrite & hitRaw) ? wBits : mie_pkg::RESET_VAL;
  assign statClrVec = (doWrite & hitStat) ? wBits : mie_pkg::RESET_VAL;
  assign evtVec = {26'h000_0000, singleBitEccFault, doubleBitEccFault, writeEccFault, 2'b00, cmdAddrFault};

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : gSrc
      if (mie_pkg::SRC_MASK[gi]) begin : gLive
        mie_src_bit uBit (
          .clk(clk),
          .rstn(rstn),
          .hwEvent(evtVec[gi]),
          .enSet(enSetVec[gi]),
          .enClr(enClrVec[gi]),
          .rawSet(rawSetVec[gi]),
          .statClr(statClrVec[gi]),
          .enable(enableVec[gi]),
          .raw(rawVec[gi])
        );
      end else begin : gDead
        assign enableVec[gi] = 1'b0;
        assign rawVec[gi] = 1'b0;
      end
    end
  endgenerate

  assign enStatVec = rawVec & enableVec;
  assign irq_next = |enStatVec;

  // read decode; set and clear both show the shared enables
  assign arTake = s_axi_arvalid & s_axi_arready;
  assign rdHit = (s_axi_araddr[7:2] == mie_pkg::OFF_RAW[7:2]) | (s_axi_araddr[7:2] == mie_pkg::OFF_ENSTAT[7:2])
    | (s_axi_araddr[7:2] == mie_pkg::OFF_ENSET[7:2]) | (s_axi_araddr[7:2] == mie_pkg::OFF_ENCLR[7:2]);
  assign rdMux = (s_axi_araddr[7:2] == mie_pkg::OFF_RAW[7:2]) ? rawVec :
    (s_axi_araddr[7:2] == mie_pkg::OFF_ENSTAT[7:2]) ? enStatVec :
    ((s_axi_araddr[7:2] == mie_pkg::OFF_ENSET[7:2]) | (s_axi_araddr[7:2] == mie_pkg::OFF_ENCLR[7:2])) ?
    enableVec : mie_pkg::RESET_VAL;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      awHave_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= ~awHave_reg & ~awTake & ~s_axi_awready;
      if (awTake) begin
        awHave_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end else if (doWrite) begin
        awHave_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wHave_reg <= 1'b0;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= ~wHave_reg & ~wTake & ~s_axi_wready;
      if (wTake) begin
        wHave_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end else if (doWrite) begin
        wHave_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mie_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wHit ? mie_pkg::RESP_OKAY : mie_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= mie_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~arTake & ~s_axi_arready;
      if (arTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdHit ? mie_pkg::RESP_OKAY : mie_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= irq_next;
    end
  end
endmodule

// ===== tb/mie_irq_ctrl_properties.sv
`timescale 1ns/100ps
module mie_irq_ctrl_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic irqOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_resv; s_axi_rvalid |-> s_axi_rdata[31:6] == 0 && s_axi_rdata[2:1] == 0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_init; !$past(rstn) |-> !irqOut && !s_axi_bvalid && !s_axi_rvalid; endproperty
  a_init: assert property (p_init) else $error("outputs high after reset");
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_bbusy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_bbusy: assert property (p_bbusy) else $error("write taken while busy");
  property p_rbusy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_rbusy: assert property (p_rbusy) else $error("read taken while busy");
  property p_irqoff; $fell(irqOut) |-> $past(s_axi_bvalid); endproperty
  a_irqoff: assert property (p_irqoff) else $error("interrupt fell without write");
endmodule
bind mie_irq_ctrl mie_irq_ctrl_properties chk (.clk, .rstn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .irqOut);

// ===== tb/mem_ctrl_irq_enable_set_clear_bench.sv
`timescale 1ns/100ps
module mem_ctrl_irq_enable_set_clear_bench;
  logic clk = 0, rstn = 0, awv = 0, wv = 0, bRdy = 0, arv = 0, rRdy = 0;
  logic awRdy, wRdy, bValid, arRdy, rValid, irq;
  logic [1:0] bResp, rResp;
  logic [3:0] flt = 4'h0, wStrb = 4'hF;
  logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
  logic [31:0] wData = 32'h0000_0000, rData, m, exp = 32'h0000_0000;
  int nMismatch = 0, totalChecks = 0;
  int bits[4] = '{5, 4, 3, 0};
  always #10 clk = ~clk;
  mie_irq_ctrl uut (.clk(clk), .rstn(rstn), .singleBitEccFault(flt[0]), .doubleBitEccFault(flt[1]),
    .writeEccFault(flt[2]), .cmdAddrFault(flt[3]), .s_axi_awaddr(awAddr), .s_axi_awvalid(awv),
    .s_axi_awready(awRdy), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wv), .s_axi_wready(wRdy),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bRdy), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arv), .s_axi_arready(arRdy), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rRdy), .irqOut(irq));
  task wrap_up;
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] want);
    totalChecks++;
    if (seen !== want) begin
      nMismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = mie_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
    awAddr <= a;
    wData <= d;
    awv <= 1;
    wv <= 1;
    bRdy <= 1;
    do begin
      @(posedge clk);
      if (awRdy) awv <= 0;
      if (wRdy) wv <= 0;
    end while (bValid !== 1'b1);
    bRdy <= 0;
    chk(32'(bResp), 32'(r));
  endtask
  task rd(input logic [7:0] a, input logic [31:0] want);
    @(posedge clk);
    arAddr <= a;
    arv <= 1;
    rRdy <= 1;
    do begin
      @(posedge clk);
      if (arRdy) arv <= 0;
    end while (rValid !== 1'b1);
    rRdy <= 0;
    chk(32'(rResp), 32'(mie_pkg::RESP_OKAY));
    chk(rData, want);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1;
    rd(mie_pkg::OFF_ENSET, 32'h0000_0000);
    rd(mie_pkg::OFF_ENCLR, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      m = 32'h1 << bits[i % 4];
      exp = (i < 4) ? (exp | m) : (exp & ~m);
      if (i == 4) begin
        wr(mie_pkg::OFF_ENSET, 32'hFFFF_FFC6);
        wr(mie_pkg::OFF_ENCLR, 32'hFFFF_FFC6);
        rd(mie_pkg::OFF_ENSET, 32'h0000_0039);
      end
      wr((i < 4) ? mie_pkg::OFF_ENSET : mie_pkg::OFF_ENCLR, m);
      rd(mie_pkg::OFF_ENSET, exp);
      rd(mie_pkg::OFF_ENCLR, exp);
    end
    flt <= 4'hF;
    @(posedge clk);
    flt <= 4'h0;
    rd(mie_pkg::OFF_RAW, 32'h0000_0039);
    chk(32'(irq), 32'h0000_0000);
    wr(mie_pkg::OFF_ENSET, 32'h0000_0020);
    rd(mie_pkg::OFF_ENSTAT, 32'h0000_0020);
    chk(32'(irq), 32'h0000_0001);
    wr(mie_pkg::OFF_ENSTAT, 32'h0000_0039);
    rd(mie_pkg::OFF_RAW, 32'h0000_0019);
    chk(32'(irq), 32'h0000_0000);
    wr(mie_pkg::OFF_RAW, 32'h0000_0020);
    rd(mie_pkg::OFF_RAW, 32'h0000_0039);
    chk(32'(irq), 32'h0000_0001);
    wr(8'h40, 32'h0000_0020, mie_pkg::RESP_SLVERR);
    // lane 0 strobe low: write must be a no-op
    wStrb <= 4'hE;
    wr(mie_pkg::OFF_ENCLR, 32'h0000_0020);
    wStrb <= 4'hF;
    rd(mie_pkg::OFF_ENSET, 32'h0000_0020);
    wr(mie_pkg::OFF_ENCLR, 32'h0000_0020);
    rd(mie_pkg::OFF_ENSET, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    // mid-run reset with enables and raw bits set
    wr(mie_pkg::OFF_ENSET, 32'h0000_0039);
    @(posedge clk);
    rstn <= 0;
    repeat (3) @(posedge clk);
    rstn <= 1;
    rd(mie_pkg::OFF_ENCLR, 32'h0000_0000);
    rd(mie_pkg::OFF_RAW, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    wrap_up;
  end
  initial begin
    #100us;
    nMismatch++;
    wrap_up;
  end
endmodule
